// file: verilog/bsmc_pkg.sv
// Package holding register map, field layout and carrier types of the I2C status block.
package bsmc_pkg;

   // Register byte addresses.
   localparam logic [15:0] ADDR_CONTROL_ONE = 16'hFFA8;
   localparam logic [15:0] ADDR_FLAG = 16'hFFA9;

   // Values after reset.
   localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
   localparam logic [7:0] FLAG_RESET = 8'h00;

   // Bus flag register field positions.
   localparam int FLAG_START_CLEAR_BIT = 7;
   localparam int FLAG_BUS_BUSY_BIT = 6;
   localparam int FLAG_INITIAL_START_BIT = 1;
   localparam int FLAG_RESERVATION_BIT = 0;

   // Control one register field positions.
   localparam int CTL_WAKE_BIT = 7;
   localparam int CTL_CLOCK_LEVEL_BIT = 5;
   localparam int CTL_DATA_LEVEL_BIT = 4;
   localparam int CTL_SPEED_BIT = 3;
   localparam int CTL_FILTER_BIT = 2;

   // Bits that software may change in each register.
   localparam logic [7:0] FLAG_WRITABLE = 8'h03;
   localparam logic [7:0] CTL_WRITABLE = 8'h8C;

   // One register access: bit writes use a single mask bit, byte writes use all eight.
   typedef struct packed {
      logic [15:0] addr;
      logic write;
      logic [7:0] mask;
      logic [7:0] data;
   } bsmc_reg_req_type;

   // State of the logic on the device clock.
   typedef struct packed {
      logic [2:0] startSync;
      logic [2:0] stopSync;
      logic [1:0] sclSync;
      logic [1:0] sdaSync;
      logic enPrev;
      logic busy;
      logic start_clear_flag;
      logic initial_start_enable;
      logic rsv;
      logic address_wake_enable;
      logic cld;
      logic dad;
      logic speed;
      logic filter;
      logic permit;
      logic wake;
      logic [7:0] rdata;
   } bsmc_ref_state_type;

   // State of the logic on the link sampling clock.
   typedef struct packed {
      logic [1:0] sclS;
      logic [1:0] sdaS;
      logic sdaPrev;
      logic startTgl;
      logic stopTgl;
   } bsmc_link_state_type;

   localparam bsmc_ref_state_type REF_RESET = '0;
   // Link samplers start at the idle-high line level, so release from reset shows no false stop.
   // A line held low across reset may show one stray start instead; pull-ups make that rare.
   localparam bsmc_link_state_type LINK_RESET = '{sclS: 2'h3, sdaS: 2'h3, sdaPrev: 1'h1,
                                                  startTgl: 1'h0, stopTgl: 1'h0};

endpackage : bsmc_pkg

// file: verilog/bsmc_i2c_status.sv
// Bus busy tracking, start permission and mode control registers of an I2C unit.
`timescale 1ns/10ps
module bsmc_i2c_status
   import bsmc_pkg::*;
(
   // Device clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Link sampling clock.
   input wire logic linkClk,
   // Register access.
   input wire bsmc_reg_req_type regReq,
   output logic [7:0] regReadData,
   // Control from the rest of the unit.
   input wire logic unitEnable,
   input wire logic startRequest,
   input wire logic startFail,
   input wire logic stopMode,
   input wire logic addressMatch,
   // Bus pins, observed only.
   input wire logic serialClockPin,
   input wire logic serialDataPin,
   // Status and mode outputs.
   output logic busBusy,
   output logic startPermit,
   output logic reservationDisable,
   output logic fastMode,
   output logic noiseFilterEnable,
   output logic wakeRequest
);

   bsmc_ref_state_type r_q;
   bsmc_ref_state_type r_d;
   bsmc_link_state_type l_q;
   bsmc_link_state_type l_d;
   logic startEv;
   logic stopEv;
   logic flagWrite;
   logic ctlWrite;

   // Merges a bit or byte write into a register, touching only writable bits.
   function automatic logic [7:0] mergeBits(input logic [7:0] old, input logic [7:0] data,
                                            input logic [7:0] mask, input logic [7:0] wr);
      logic [7:0] sel;
      sel = mask & wr;
      mergeBits = (old & ~sel) | (data & sel);
   endfunction : mergeBits

   // Link domain: pins pass two flip-flops, then start and stop become toggles.
   always_comb begin
      l_d = l_q;
      l_d.sclS = {l_q.sclS[0], serialClockPin};
      l_d.sdaS = {l_q.sdaS[0], serialDataPin};
      l_d.sdaPrev = l_q.sdaS[1];
      // Data falling while clock high is a start; data rising is a stop.
      if (l_q.sclS[1] && l_q.sdaPrev && !l_q.sdaS[1]) begin
         l_d.startTgl = !l_q.startTgl;
      end
      if (l_q.sclS[1] && !l_q.sdaPrev && l_q.sdaS[1]) begin
         l_d.stopTgl = !l_q.stopTgl;
      end
   end

   always_ff @(posedge linkClk or posedge rst) begin
      if (rst) begin
         l_q <= LINK_RESET;
      end else begin
         l_q <= l_d;
      end
   end

   // Toggle edges seen after the two synchroniser stages mark one event each.
   assign startEv = r_q.startSync[2] ^ r_q.startSync[1];
   assign stopEv = r_q.stopSync[2] ^ r_q.stopSync[1];
   assign flagWrite = regReq.write && (regReq.addr == ADDR_FLAG);
   assign ctlWrite = regReq.write && (regReq.addr == ADDR_CONTROL_ONE);

   // Device domain next state.
   always_comb begin
      logic [7:0] fw;
      logic [7:0] cw;
      fw = 8'h00;
      cw = 8'h00;
      r_d = r_q;
      r_d.startSync = {r_q.startSync[1:0], l_q.startTgl};
      r_d.stopSync = {r_q.stopSync[1:0], l_q.stopTgl};
      // Pins are also synchronised here directly, since the level monitors are slow.
      r_d.sclSync = {r_q.sclSync[0], serialClockPin};
      r_d.sdaSync = {r_q.sdaSync[0], serialDataPin};
      r_d.enPrev = unitEnable;

      // Writable flag bits only; the start clear and busy positions are masked off.
      fw = mergeBits({6'h00, r_q.initial_start_enable, r_q.rsv}, regReq.data, regReq.mask,
                     FLAG_WRITABLE);
      // Setup bits are locked while the unit runs, so a stray write cannot upset a transfer.
      if (flagWrite && !unitEnable) begin
         r_d.initial_start_enable = fw[FLAG_INITIAL_START_BIT];
         r_d.rsv = fw[FLAG_RESERVATION_BIT];
      end
      if (startEv) begin
         r_d.initial_start_enable = 1'b0;
      end

      // Level monitor bits are outside the writable mask.
      cw = mergeBits({r_q.address_wake_enable, 1'b0, 2'b00, r_q.speed, r_q.filter, 2'b00}, regReq.data,
                     regReq.mask, CTL_WRITABLE);
      if (ctlWrite) begin
         r_d.address_wake_enable = cw[CTL_WAKE_BIT];
         r_d.speed = cw[CTL_SPEED_BIT];
         r_d.filter = cw[CTL_FILTER_BIT];
      end

      // Bus busy and start permission.
      if (!unitEnable) begin
         r_d.busy = 1'b0;
         r_d.permit = 1'b0;
         r_d.start_clear_flag = 1'b0;
         r_d.cld = 1'b0;
         r_d.dad = 1'b0;
      end else begin
         r_d.cld = r_q.sclSync[1];
         r_d.dad = r_q.sdaSync[1];
         if (!r_q.enPrev) begin
            r_d.busy = !r_q.initial_start_enable;
            r_d.permit = r_q.initial_start_enable;
         end
         if (stopEv) begin
            r_d.busy = 1'b0;
            r_d.permit = 1'b1;
         end
         // A start that lands with a stop wins, so the bus is never wrongly shown free.
         if (startEv) begin
            r_d.busy = 1'b1;
         end
         if (startRequest) begin
            r_d.start_clear_flag = 1'b0;
         end
         if (startFail) begin
            r_d.start_clear_flag = 1'b1;
         end
      end

      // Address wakeup only acts while the processor is stopped and wake is enabled.
      r_d.wake = r_q.address_wake_enable && stopMode && addressMatch;

      // Read data lags the address by one clock; unmapped addresses read zero.
      if (regReq.addr == ADDR_FLAG) begin
         r_d.rdata = {r_q.start_clear_flag, r_q.busy, 4'h0, r_q.initial_start_enable, r_q.rsv};
      end else if (regReq.addr == ADDR_CONTROL_ONE) begin
         r_d.rdata = {r_q.address_wake_enable, 1'b0, r_q.cld, r_q.dad, r_q.speed, r_q.filter,
                      2'b00};
      end else begin
         r_d.rdata = 8'h00;
      end
   end

   // Device domain register; reset clears both registers.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         r_q <= REF_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   // Outputs come straight from flip-flops.
   assign regReadData = r_q.rdata;
   assign busBusy = r_q.busy;
   assign startPermit = r_q.permit;
   assign reservationDisable = r_q.rsv;
   assign fastMode = r_q.speed;
   assign noiseFilterEnable = r_q.filter;
   assign wakeRequest = r_q.wake;

   // Busy takes its starting value from the initial start bit on enable.
   property p_busyInit;
      @(posedge ref_clk) disable iff (rst)
      (unitEnable && !r_q.enPrev && !startEv && !stopEv) |=> (busBusy == !$past(r_q.initial_start_enable));
   endproperty
   a_busyInit: assert property (p_busyInit) else $error("busy start value wrong");

   // Stop releases the bus and a start claims it.
   property p_busyEvents;
      @(posedge ref_clk) disable iff (rst)
      (unitEnable && r_q.enPrev && (startEv || stopEv)) |=> (busBusy == $past(startEv));
   endproperty
   a_busyEvents: assert property (p_busyEvents) else $error("busy ignores bus events");

   // Disabled unit shows nothing busy, permitted or sensed.
   property p_disabled;
      @(posedge ref_clk) disable iff (rst)
      !unitEnable [*2] |-> (!busBusy && !startPermit && (r_q.cld == 1'b0) && !r_q.dad);
   endproperty
   a_disabled: assert property (p_disabled) else $error("state kept while disabled");

   // Without initial start, enabling gives no permission until a stop.
   property p_permitWait;
      @(posedge ref_clk) disable iff (rst)
      (unitEnable && !r_q.enPrev && !r_q.initial_start_enable && !stopEv) |=> !startPermit;
   endproperty
   a_permitWait: assert property (p_permitWait) else $error("start allowed before stop");

   // With initial start, permission follows enable at once.
   property p_permitNow;
      @(posedge ref_clk) disable iff (rst)
      (unitEnable && !r_q.enPrev && r_q.initial_start_enable) |=> startPermit;
   endproperty
   a_permitNow: assert property (p_permitNow) else $error("start not allowed at enable");

   // A detected start clears the initial start bit.
   property p_stcenClear;
      @(posedge ref_clk) disable iff (rst)
      startEv |=> !r_q.initial_start_enable;
   endproperty
   a_stcenClear: assert property (p_stcenClear) else $error("initial start not cleared");

   // Reservation disable moves only on a flag register write.
   property p_rsvStable;
      @(posedge ref_clk) disable iff (rst)
      !flagWrite |=> $stable(reservationDisable);
   endproperty
   a_rsvStable: assert property (p_rsvStable) else $error("reservation bit moved");

   // Writes never alter the start clear flag except through its own causes.
   property p_flagReadOnly;
      @(posedge ref_clk) disable iff (rst)
      (flagWrite && unitEnable && r_q.enPrev && !startRequest && !startFail) |=>
         $stable(r_q.start_clear_flag);
   endproperty
   a_flagReadOnly: assert property (p_flagReadOnly) else $error("read-only flag written");

   // Unused control one bits always read zero.
   property p_ctlZero;
      @(posedge ref_clk) disable iff (rst)
      (regReq.addr == ADDR_CONTROL_ONE) |=> ((regReadData & 8'h43) == 8'h00);
   endproperty
   a_ctlZero: assert property (p_ctlZero) else $error("reserved bits not zero");

   // Wake request follows enable, stop mode and match with one clock of delay.
   property p_wake;
      @(posedge ref_clk) disable iff (rst)
      (r_q.address_wake_enable && stopMode && addressMatch) |=> wakeRequest;
   endproperty
   a_wake: assert property (p_wake) else $error("wake request wrong");

   // Without wake enable, stop mode and a match together, no wakeup is raised.
   property p_wakeOff;
      @(posedge ref_clk) disable iff (rst)
      !(r_q.address_wake_enable && stopMode && addressMatch) |=> !wakeRequest;
   endproperty
   a_wakeOff: assert property (p_wakeOff) else $error("wake raised while not allowed");

   // The clock level bit copies the synchronised pin while the unit runs.
   property p_clockLevel;
      @(posedge ref_clk) disable iff (rst)
      unitEnable |=> (r_q.cld == $past(r_q.sclSync[1]));
   endproperty
   a_clockLevel: assert property (p_clockLevel) else $error("clock level not tracked");

   // The data level bit copies its synchronised pin in the same way.
   property p_dataLevel;
      @(posedge ref_clk) disable iff (rst)
      unitEnable |=> (r_q.dad == $past(r_q.sdaSync[1]));
   endproperty
   a_dataLevel: assert property (p_dataLevel) else $error("data level not tracked");

   // A write while stopped cannot plant a value in the read-only level bits.
   property p_levelReadOnly;
      @(posedge ref_clk) disable iff (rst)
      (ctlWrite && !unitEnable) |=> (!r_q.cld && !r_q.dad);
   endproperty
   a_levelReadOnly: assert property (p_levelReadOnly) else $error("level bit written");

   // Speed select moves only on a control one write.
   property p_speedHold;
      @(posedge ref_clk) disable iff (rst)
      !ctlWrite |=> $stable(fastMode);
   endproperty
   a_speedHold: assert property (p_speedHold) else $error("speed select moved");

   // Noise filter enable moves only on a control one write.
   property p_filterHold;
      @(posedge ref_clk) disable iff (rst)
      !ctlWrite |=> $stable(noiseFilterEnable);
   endproperty
   a_filterHold: assert property (p_filterHold) else $error("filter enable moved");

   // Initial start is only ever set by a write while the unit is stopped.
   property p_stcenHold;
      @(posedge ref_clk) disable iff (rst)
      (!flagWrite || unitEnable) |=> !$rose(r_q.initial_start_enable);
   endproperty
   a_stcenHold: assert property (p_stcenHold) else $error("initial start set by hardware");

   // Busy rises only on a detected start or at the enable edge.
   property p_busyRise;
      @(posedge ref_clk) disable iff (rst)
      $rose(busBusy) |-> ($past(startEv) || !$past(r_q.enPrev));
   endproperty
   a_busyRise: assert property (p_busyRise) else $error("busy set without cause");

   // Busy falls only on a detected stop or when the unit is stopped.
   property p_busyFall;
      @(posedge ref_clk) disable iff (rst)
      $fell(busBusy) |-> ($past(stopEv) || !$past(unitEnable));
   endproperty
   a_busyFall: assert property (p_busyFall) else $error("busy cleared without cause");

   // Permission appears only after a stop, unless initial start was armed.
   property p_permitRise;
      @(posedge ref_clk) disable iff (rst)
      $rose(startPermit) |-> ($past(stopEv) || $past(r_q.initial_start_enable));
   endproperty
   a_permitRise: assert property (p_permitRise) else $error("start allowed too early");

   // The busy bit of the flag register reads the live busy flag.
   property p_flagRead;
      @(posedge ref_clk) disable iff (rst)
      (regReq.addr == ADDR_FLAG) |=> (regReadData[FLAG_BUS_BUSY_BIT] == $past(busBusy));
   endproperty
   a_flagRead: assert property (p_flagRead) else $error("busy bit reads wrong");

   // Reservation disable is locked against writes while the unit runs.
   property p_rsvLocked;
      @(posedge ref_clk) disable iff (rst)
      (flagWrite && unitEnable) |=> $stable(reservationDisable);
   endproperty
   a_rsvLocked: assert property (p_rsvLocked) else $error("reservation written in use");

endmodule : bsmc_i2c_status

// file: verification/bsmc_bus_node.sv
// Model of another bus node that frames start and stop conditions on the shared lines.
`timescale 1ns/10ps
module bsmc_bus_node (
   // Open-drain line pulls, low while this node pulls its line down.
   output logic sclOeN,
   output logic sdaOeN
);
   // Both lines are released at time zero, so the pull-ups hold them high.
   initial begin
      sclOeN = 1'b1;
      sdaOeN = 1'b1;
   end

   // Start: data falls while the clock is high, then the clock is pulled low.
   task automatic frame_start(input int phaseNs);
      sdaOeN = 1'b0;
      #(phaseNs);
      sclOeN = 1'b0;
      #(phaseNs);
   endtask : frame_start

   // Stop: clock low first so no false start, then data rises while clock is high.
   task automatic frame_stop(input int phaseNs);
      sclOeN = 1'b0;
      #(phaseNs);
      sdaOeN = 1'b0;
      #(phaseNs);
      sclOeN = 1'b1;
      #(phaseNs);
      sdaOeN = 1'b1;
      #(phaseNs);
   endtask : frame_stop
endmodule : bsmc_bus_node

// file: verification/tb_i2c_bus_status_and_mode_control.sv
// Self-checking bench for the bus status and mode control block.
`timescale 1ns/10ps
module tb_i2c_bus_status_and_mode_control
   import bsmc_pkg::*;
   ;
   logic ref_clk = 1'b0;
   logic linkClk = 1'b0;
   logic rst = 1'b1;
   bsmc_reg_req_type regReq = '0;
   logic unitEnable = 1'b0, startRequest = 1'b0, startFail = 1'b0;
   logic stopMode = 1'b0, addressMatch = 1'b0;
   logic [7:0] regReadData, rv, d;
   logic busBusy, startPermit, reservationDisable, fastMode, noiseFilterEnable, wakeRequest;
   logic sclOeN, sdaOeN;
   int err_count = 0, total_checks = 0;

   // Device clock, and a link clock offset so the two never share edges.
   always #2.5 ref_clk = ~ref_clk;
   initial #7.3 forever #24 linkClk = ~linkClk;

   // A released line reads high through its pull-up, so the pull enable is the level.
   bsmc_bus_node node (.sclOeN(sclOeN), .sdaOeN(sdaOeN));
   bsmc_i2c_status dut (.ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .regReq(regReq),
      .regReadData(regReadData), .unitEnable(unitEnable), .startRequest(startRequest),
      .startFail(startFail), .stopMode(stopMode), .addressMatch(addressMatch),
      .serialClockPin(sclOeN), .serialDataPin(sdaOeN), .busBusy(busBusy),
      .startPermit(startPermit), .reservationDisable(reservationDisable), .fastMode(fastMode),
      .noiseFilterEnable(noiseFilterEnable), .wakeRequest(wakeRequest));

   // Expected control byte: writable bits kept, level bits only while enabled.
   function automatic logic [7:0] ctl_exp(input logic [7:0] v, input logic scl,
      input logic sda, input logic en);
      return (v & 8'h8C) | {2'b00, en & scl, en & sda, 4'h0};
   endfunction : ctl_exp

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Write strobe stands for exactly one edge.
   task automatic wr(input logic [15:0] a, input logic [7:0] m, input logic [7:0] v);
      @(posedge ref_clk);
      regReq <= '{addr: a, write: 1'b1, mask: m, data: v};
      @(posedge ref_clk);
      regReq.write <= 1'b0;
   endtask : wr

   // Read data is registered, so it is taken a safe margin after the address settles.
   task automatic rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      regReq.addr <= a;
      repeat (3) @(posedge ref_clk);
      #1 v = regReadData;
   endtask : rd

   task automatic set_enable(input logic v);
      @(posedge ref_clk);
      unitEnable <= v;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : set_enable

   task automatic pulse_fail(input logic v);
      @(posedge ref_clk);
      startFail <= v;
      startRequest <= ~v;
      @(posedge ref_clk);
      startFail <= 1'b0;
      startRequest <= 1'b0;
   endtask : pulse_fail

   // Line events cross two synchronisers, so the wait is bounded rather than fixed.
   task automatic wait_busy(input logic exp);
      int n;
      for (n = 0; n < 400 && busBusy !== exp; n++) @(posedge ref_clk);
      #1;
   endtask : wait_busy

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report

   // Watchdog sized well beyond the few microseconds the tests need.
   initial begin
      #200000;
      err_count++;
      final_report();
   end

   initial begin
      void'($urandom(75462));
      // Both domains reset asynchronously, so two device cycles are enough.
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rd(ADDR_CONTROL_ONE, rv); check("ctl reset", rv, 8'h00);
      rd(ADDR_FLAG, rv); check("flag reset", rv, 8'h00);
      rd(16'hFFAA, rv); check("unmapped", rv, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         wr(ADDR_CONTROL_ONE, 8'hFF, d);
         rd(ADDR_CONTROL_ONE, rv); check("ctl byte", rv, ctl_exp(d, 1'b1, 1'b1, 1'b0));
         check("fast", {7'h00, fastMode}, {7'h00, d[3]});
         check("filter", {7'h00, noiseFilterEnable}, {7'h00, d[2]});
      end
      wr(ADDR_CONTROL_ONE, 8'h28, ~d);
      d[3] = ~d[3];
      rd(ADDR_CONTROL_ONE, rv); check("ctl bit", rv, ctl_exp(d, 1'b1, 1'b1, 1'b0));
      wr(ADDR_FLAG, 8'hFF, 8'hFF);
      rd(ADDR_FLAG, rv); check("flag ro", rv, 8'h03);
      wr(ADDR_FLAG, 8'h02, 8'h00);
      $display("test registers done");
      set_enable(1'b1);
      check("busy on", {5'h00, busBusy, startPermit, reservationDisable}, 8'h05);
      rd(ADDR_CONTROL_ONE, rv); check("levels hi", rv, ctl_exp(d, 1'b1, 1'b1, 1'b1));
      wr(ADDR_FLAG, 8'hFF, 8'h00);
      rd(ADDR_FLAG, rv); check("flag locked", rv, 8'h41);
      node.frame_stop(200);
      wait_busy(1'b0); check("stop", {6'h00, busBusy, startPermit}, 8'h01);
      node.frame_start(200);
      wait_busy(1'b1); check("start", {7'h00, busBusy}, 8'h01);
      rd(ADDR_CONTROL_ONE, rv); check("levels lo", rv, ctl_exp(d, 1'b0, 1'b0, 1'b1));
      pulse_fail(1'b1);
      rd(ADDR_FLAG, rv); check("clear flag", rv, 8'hC1);
      pulse_fail(1'b0);
      rd(ADDR_FLAG, rv); check("clear flag off", rv, 8'h41);
      node.frame_stop(600);
      wait_busy(1'b0);
      set_enable(1'b0);
      check("disabled", {6'h00, busBusy, startPermit}, 8'h00);
      rd(ADDR_CONTROL_ONE, rv); check("levels off", rv, ctl_exp(d, 1'b1, 1'b1, 1'b0));
      $display("test initial start off done");
      wr(ADDR_FLAG, 8'h02, 8'h02);
      wr(ADDR_FLAG, 8'h01, 8'h00);
      rd(ADDR_FLAG, rv); check("init start set", rv, 8'h02);
      set_enable(1'b1);
      check("released", {5'h00, busBusy, startPermit, reservationDisable}, 8'h02);
      check("bus idle", {6'h00, sclOeN, sdaOeN}, 8'h03);
      node.frame_start(200);
      wait_busy(1'b1);
      rd(ADDR_FLAG, rv); check("init start clr", rv, 8'h40);
      node.frame_stop(200);
      wait_busy(1'b0);
      set_enable(1'b0);
      $display("test initial start on done");
      @(posedge ref_clk);
      stopMode <= 1'b1;
      addressMatch <= 1'b1;
      wr(ADDR_CONTROL_ONE, 8'h80, 8'h80);
      repeat (3) @(posedge ref_clk);
      #1 check("wake on", {7'h00, wakeRequest}, 8'h01);
      wr(ADDR_CONTROL_ONE, 8'h80, 8'h00);
      repeat (3) @(posedge ref_clk);
      #1 check("wake off", {7'h00, wakeRequest}, 8'h00);
      $display("test wake done");
      // Arm both setup bits so that the second reset has something to clear.
      wr(ADDR_FLAG, 8'hFF, 8'h03);
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rd(ADDR_CONTROL_ONE, rv); check("ctl rereset", rv, 8'h00);
      rd(ADDR_FLAG, rv); check("flag rereset", rv, 8'h00);
      $display("test second reset done");
      final_report();
   end
endmodule : tb_i2c_bus_status_and_mode_control
